//--- bench/smbus_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module smbus_host_model (
  output logic      scl,
  output logic      sda_drv,
  input  wire logic sda_wire
);
  // ***********************************************************************
  // bit, byte and transfer sequencing of the host
  // ***********************************************************************
  localparam int HALF = 800;

  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic bit_io(input logic b, output logic r);
    #(HALF/4) sda_drv = b;
    #(3*HALF/4) scl = 1'b1;
    #(HALF/2) r = sda_wire;
    #(HALF/2) scl = 1'b0;
  endtask

  task automatic start_c();
    #(HALF/4) sda_drv = 1'b1;
    #HALF scl = 1'b1;
    #HALF sda_drv = 1'b0;
    #HALF scl = 1'b0;
  endtask

  task automatic send(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask

  // mode 0 write, 1 read, 2 alert address query
  task automatic xfer(input logic [6:0] a, input logic [1:0] mode, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd, output logic ok);
    logic k;
    logic r;
    ok = 1'b1;
    rd = 8'h00;
    start_c();
    if (mode == 2'h2) begin
      send({smbus_io_pkg::ALERT_RESP, 1'b1}, k);
    end else begin
      send({a, 1'b0}, k);
      ok = k;
      send(idx, k);
      ok = ok & k;
      if (mode == 2'h0) begin
        send(wd, k);
      end else begin
        start_c();
        send({a, 1'b1}, k);
      end
    end
    ok = ok & k;
    if (mode != 2'h0) begin
      for (int i = 7; i >= 0; i--) bit_io(1'b1, rd[i]);
      bit_io(1'b1, r);
    end
    #(HALF/4) sda_drv = 1'b0;
    #HALF scl = 1'b1;
    #HALF sda_drv = 1'b1;
    #HALF;
  endtask
endmodule
`default_nettype wire

//--- bench/smbus_io_chk.sv
`timescale 1ns/100ps
`default_nettype none
module smbus_io_chk #(
  parameter int PINS = 8
) (
  input  wire logic            clk_sys,
  input  wire logic            rst,
  input  wire logic            link_clk,
  input  wire logic            scl_i,
  input  wire logic            sda_o,
  input  wire logic            sda_oe,
  input  wire logic [PINS-1:0] port_pin_i,
  input  wire logic [PINS-1:0] port_pin_oe,
  input  wire logic            alert_n_o,
  input  wire logic            alert_n_oe
);
  // ***********************************************************************
  // age of the last pin and serial clock movement, saturating
  // ***********************************************************************
  logic [PINS-1:0] pin_seen_r;
  logic            scl_seen_r;
  logic [7:0]      pin_age_r;
  logic [9:0]      scl_age_r;

  always_ff @(posedge clk_sys) begin
    pin_seen_r <= port_pin_i;
    scl_seen_r <= scl_i;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_age_r <= 8'hFF;
      scl_age_r <= 10'h3FF;
    end else begin
      pin_age_r <= (port_pin_i != pin_seen_r) ? 8'h00 : pin_age_r + {7'h00, pin_age_r != 8'hFF};
      scl_age_r <= (scl_i != scl_seen_r) ? 10'h000 : scl_age_r + {9'h000, scl_age_r != 10'h3FF};
    end
  end

  chk_sda_pull_only: assert property (@(posedge clk_sys) disable iff (rst) sda_oe |-> !sda_o)
    else $error("data line driven high");
  chk_alert_pull_only: assert property (@(posedge clk_sys) disable iff (rst) alert_n_oe |-> !alert_n_o)
    else $error("alert line driven high");
  chk_alert_has_cause: assert property (@(posedge clk_sys) disable iff (rst) $rose(alert_n_oe) |-> pin_age_r < 8'd12)
    else $error("alert raised without a pin change");
  chk_alert_clear_link: assert property (@(posedge clk_sys) disable iff (rst) $fell(alert_n_oe) |-> scl_age_r < 10'd400)
    else $error("alert dropped without link traffic");
  chk_drive_by_write: assert property (@(posedge clk_sys) disable iff (rst) $changed(port_pin_oe) |-> scl_age_r < 10'd400)
    else $error("pin drive changed without link traffic");
  chk_reset_quiet: assert property (@(posedge clk_sys) rst |=> (port_pin_oe == '0) && !alert_n_oe)
    else $error("pins or alert driven in reset");
  chk_reset_sda_free: assert property (@(posedge link_clk) rst [*6] |-> !sda_oe)
    else $error("data line pulled in reset");
  chk_sda_steady_high: assert property (@(posedge link_clk) disable iff (rst) scl_i && $past(scl_i, 5) |-> $stable(sda_oe))
    else $error("data line moved while clock high");
endmodule
bind smbus_io_expander_fan smbus_io_chk #(.PINS(PINS)) chk (.clk_sys, .rst, .link_clk, .scl_i, .sda_o, .sda_oe,
  .port_pin_i, .port_pin_oe, .alert_n_o, .alert_n_oe);
`default_nettype wire

//--- bench/test_smbus_io_expander_fan.sv
`timescale 1ns/100ps
`default_nettype none
module test_smbus_io_expander_fan;
  // ***********************************************************************
  // clocks, wires and the device
  // ***********************************************************************
  logic       clk_sys = 1'b0;
  logic       link_clk = 1'b0;
  logic       rst = 1'b1;
  logic       ce = 1'b1;
  logic       scl, sda_drv, sda_o, sda_oe, sda_w, alert_n_o, alert_n_oe, ok;
  logic [2:0] strap, pins_a, rate;
  logic [6:0] own;
  logic [7:0] ext, pin_o, pin_oe, pin_w, rd;
  int         fails = 0;
  int         checked = 0;

  always #2.5 clk_sys = ~clk_sys;
  initial begin
    #1.3;
    forever #40 link_clk = ~link_clk;
  end
  assign sda_w = sda_drv & (~sda_oe | sda_o);
  assign pin_w = (pin_oe & pin_o) | (~pin_oe & ext);

  smbus_io_expander_fan dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .link_clk(link_clk), .scl_i(scl),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .addr_strap_hi(pins_a[2]), .addr_strap_mid(pins_a[1]),
    .addr_strap_lo(pins_a[0]), .port_pin_i(pin_w), .port_pin_o(pin_o), .port_pin_oe(pin_oe),
    .alert_n_o(alert_n_o), .alert_n_oe(alert_n_oe));
  smbus_host_model host (.scl(scl), .sda_drv(sda_drv), .sda_wire(sda_w));

  function automatic logic [7:0] fan_oe(input logic [2:0] r);
    return {r, ~|r, 4'h0};
  endfunction

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic op(input logic [1:0] mode, input logic [7:0] idx, input logic [7:0] wd);
    host.xfer(own, mode, idx, wd, rd, ok);
    check("acknowledge", {7'h00, ok}, 8'h01);
  endtask

  task automatic wait_alert();
    for (int n = 0; n < 60; n++) begin
      if (alert_n_oe === 1'b1) return;
      @(posedge clk_sys);
      #1;
    end
    fails++;
    $display("FAIL alert expected 1 seen %b", alert_n_oe);
    report_and_stop();
  endtask

  initial begin
    void'($urandom(89));
    strap = 3'($urandom);
    pins_a = strap;
    ext = 8'($urandom);
    rate = 3'($urandom_range(7, 1));
    own = {smbus_io_pkg::ADDR_UPPER, strap};
    repeat (160) @(posedge clk_sys);
    #1 rst = 1'b0;
    repeat (400) @(posedge clk_sys);
    #1 pins_a = ~strap;
    host.xfer({smbus_io_pkg::ADDR_UPPER, ~strap}, 2'h0, smbus_io_pkg::REG_DEVICE_CONFIG, 8'h03, rd, ok);
    check("moved address ack", {7'h00, ok}, 8'h00);
    op(2'h1, smbus_io_pkg::REG_DEVICE_CONFIG, 8'h00);
    check("config reset", rd, smbus_io_pkg::RST_ZERO);
    $display("test address latch done");
    op(2'h0, smbus_io_pkg::REG_COOLING_RATE, {5'h00, rate});
    op(2'h0, smbus_io_pkg::REG_PIN_DIRECTION, 8'h03);
    op(2'h0, smbus_io_pkg::REG_IRQ_ENABLE, 8'hFF);
    op(2'h0, smbus_io_pkg::REG_DEVICE_CONFIG, 8'h03);
    check("pin drive", pin_oe, fan_oe(rate));
    check("pin value", pin_o, 8'h00);
    $display("test fan drive done");
    @(posedge clk_sys);
    #1 ext = ext ^ 8'h54;
    wait_alert();
    check("alert raised", {7'h00, alert_n_oe}, 8'h01);
    host.xfer(own, 2'h2, 8'h00, 8'h00, rd, ok);
    check("alert address ack", {7'h00, ok}, 8'h01);
    check("alert address reply", rd, {own, 1'b0});
    check("alert after reply", {7'h00, alert_n_oe}, 8'h00);
    $display("test alert done");
    op(2'h1, smbus_io_pkg::REG_CHANGE_FLAGS, 8'h00);
    check("flags", rd, 8'h04);
    op(2'h1, smbus_io_pkg::REG_CHANGE_FLAGS, 8'h00);
    check("flags cleared", rd, 8'h00);
    $display("test change flags done");
    op(2'h0, smbus_io_pkg::REG_IRQ_ENABLE, 8'hFB);
    @(posedge clk_sys);
    #1 ext = ext ^ 8'h04;
    ce = 1'b0;
    repeat (20) @(posedge clk_sys);
    #1 ce = 1'b1;
    repeat (20) @(posedge clk_sys);
    #1;
    check("masked alert", {7'h00, alert_n_oe}, 8'h00);
    op(2'h1, smbus_io_pkg::REG_CHANGE_FLAGS, 8'h00);
    check("masked flags", rd, 8'h04);
    $display("test mask and clock enable done");
    op(2'h0, smbus_io_pkg::REG_DRIVE_SELECT, 8'h01);
    op(2'h0, smbus_io_pkg::REG_PORT_LEVELS, 8'h01);
    check("low pin drive", {pin_oe[3:0], pin_o[3:0]}, 8'h31);
    op(2'h1, smbus_io_pkg::REG_PORT_LEVELS, 8'h00);
    check("levels read", rd & 8'h03, 8'h01);
    $display("test drive select done");
    report_and_stop();
  end
endmodule
`default_nettype wire

//--- hw/reg_xfer_if.sv
`timescale 1ns/100ps
`default_nettype none
interface reg_xfer_if;
  logic                   ev_tgl;
  smbus_io_pkg::ev_kind_t ev_kind;
  logic [7:0]             ev_idx;
  logic [7:0]             ev_data;
  logic                   ack_tgl;
  logic [7:0]             rd_data;
  logic                   alert_lvl;
  modport link (output ev_tgl, ev_kind, ev_idx, ev_data, input ack_tgl, rd_data, alert_lvl);
  modport sys  (input ev_tgl, ev_kind, ev_idx, ev_data, output ack_tgl, rd_data, alert_lvl);
endinterface
`default_nettype wire

//--- hw/smbus_io_expander_fan.sv
// What this block does
// (R1) Slave address is 0100 followed by the three strap levels.
// (R2) Strap levels are caught once after reset, later changes ignored.
// (R3) While alert is raised, also answers the alert response address 0001100 with its own address.
// (R4) Each pin is input or output; outputs push-pull or open-drain.
// (R5) Any change on an input pin sets its change flag, never masked.
// (R6) Global enable, pin enable and input direction let a change raise alert.
// (R7) Either enable at zero keeps a pin change from raising alert.
// (R8) Alert drops after alert address answered or flags read.
// (R9) Alert output is open-drain, active low.
// (R10) Serial data line is only pulled low or released.
// (R11) Fan mode drives upper four pins from rate register, ignoring their config.
// (R12) Fan pins: three low-active rate selects and low-active shutdown, no alerts.
// (R13) Host reads: address write, index, repeated start, address read, one byte.
// (R14) Host writes: address, index, data; the byte lands in that register, but flags ignore writes and port levels keep non-output bits.
// (R15) Index 00h..06h selects config, direction, drive, flags, enables, levels, rate.
// (R16) Reset loads every register with 00h, the port levels with FFh.
// (R17) Direction bit one makes an output, zero an input.
// (R18) Drive bit one gives push-pull, zero open-drain.
// (R19) A read of the flags returns them, then clears them; a change in the same cycle still sets its flag.
// (R20) Rate selects carry the inverted field; shutdown low only when field is zero.
// (R21) Inputs are synchronised and compared to the last level to find changes.
`timescale 1ns/100ps
`default_nettype none
module smbus_io_expander_fan #(
  parameter int PINS = 8
) (
  input  wire logic            clk_sys,
  input  wire logic            rst,
  input  wire logic            ce,
  input  wire logic            link_clk,
  input  wire logic            scl_i,
  input  wire logic            sda_i,
  output logic                 sda_o,
  output logic                 sda_oe,
  input  wire logic            addr_strap_hi,
  input  wire logic            addr_strap_mid,
  input  wire logic            addr_strap_lo,
  input  wire logic [PINS-1:0] port_pin_i,
  output logic      [PINS-1:0] port_pin_o,
  output logic      [PINS-1:0] port_pin_oe,
  output logic                 alert_n_o,
  output logic                 alert_n_oe
);
  reg_xfer_if xf ();

  // ***********************************************************************
  // link side
  // ***********************************************************************
  smbus_link_slave u_link (
    .link_clk (link_clk),
    .rst      (rst),
    .scl_i    (scl_i),
    .sda_i    (sda_i),
    .strap    ({addr_strap_hi, addr_strap_mid, addr_strap_lo}),
    .sda_o    (sda_o),
    .sda_oe   (sda_oe),
    .xf       (xf.link)
  );

  // ***********************************************************************
  // events from the link
  // ***********************************************************************
  logic [2:0] ev_s_r;
  logic       ev_edge;
  logic       wr_ev;
  logic       rd_ev;
  logic       ara_ev;
  logic       rd_flags;

  always_ff @(posedge clk_sys) begin
    if (rst) ev_s_r <= 3'h0;
    else if (ce) ev_s_r <= {ev_s_r[1:0], xf.ev_tgl};
  end

  assign ev_edge  = ce && (ev_s_r[2] ^ ev_s_r[1]);
  assign wr_ev    = ev_edge && xf.ev_kind == smbus_io_pkg::EV_WRITE;
  assign rd_ev    = ev_edge && xf.ev_kind == smbus_io_pkg::EV_READ;
  assign ara_ev   = ev_edge && xf.ev_kind == smbus_io_pkg::EV_ARA;
  assign rd_flags = rd_ev && xf.ev_idx == smbus_io_pkg::REG_CHANGE_FLAGS;

  function automatic logic wr_hit(input logic [7:0] idx);
    return wr_ev && xf.ev_idx == idx;
  endfunction

  // ***********************************************************************
  // registers
  // ***********************************************************************
  logic [7:0]      device_config_r;
  logic [7:0]      pin_direction_r;
  logic [7:0]      drive_select_r;
  logic [7:0]      change_flags_r;
  logic [7:0]      change_flags_nxt;
  logic [7:0]      change_irq_enable_bits_r;
  logic [7:0]      port_levels_r;
  logic [7:0]      cooling_rate_select_r;
  logic            fan_on;
  logic            global_irq_enable;
  logic [PINS-1:0] fan_mask;
  logic [PINS-1:0] out_mask;
  logic [PINS-1:0] in_mask;

  assign fan_on            = device_config_r[smbus_io_pkg::CFG_FAN_BIT];
  assign global_irq_enable = device_config_r[smbus_io_pkg::CFG_IE_BIT];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      device_config_r          <= smbus_io_pkg::RST_ZERO; // R16
      pin_direction_r          <= smbus_io_pkg::RST_ZERO;
      drive_select_r           <= smbus_io_pkg::RST_ZERO;
      change_irq_enable_bits_r <= smbus_io_pkg::RST_ZERO;
      cooling_rate_select_r    <= smbus_io_pkg::RST_ZERO;
    end else if (ce) begin
      if (wr_hit(smbus_io_pkg::REG_DEVICE_CONFIG)) device_config_r <= xf.ev_data; // R14 R15
      if (wr_hit(smbus_io_pkg::REG_PIN_DIRECTION)) pin_direction_r <= xf.ev_data;
      if (wr_hit(smbus_io_pkg::REG_DRIVE_SELECT)) drive_select_r <= xf.ev_data;
      if (wr_hit(smbus_io_pkg::REG_IRQ_ENABLE)) change_irq_enable_bits_r <= xf.ev_data;
      if (wr_hit(smbus_io_pkg::REG_COOLING_RATE)) cooling_rate_select_r <= xf.ev_data;
    end
  end

  // port levels keep their old value on bits that are not outputs
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      port_levels_r <= smbus_io_pkg::RST_PORT_LEVELS; // R16
    end else if (ce && wr_hit(smbus_io_pkg::REG_PORT_LEVELS)) begin
      port_levels_r <= (port_levels_r & ~out_mask) | (xf.ev_data & out_mask);
    end
  end

  // ***********************************************************************
  // pin input sampling and change detection
  // ***********************************************************************
  logic [PINS-1:0] pin_s1_r;
  logic [PINS-1:0] pin_s2_r;
  logic [PINS-1:0] pin_s3_r;
  logic [PINS-1:0] pin_lvl_r;
  logic [PINS-1:0] pin_agree;
  logic [PINS-1:0] pin_chg;
  logic [1:0]      prime_r;
  logic            primed;

  assign primed    = prime_r == smbus_io_pkg::SETTLE_COUNT;
  assign pin_agree = ~(pin_s2_r ^ pin_s3_r);
  assign pin_chg   = primed ? (pin_agree & (pin_s3_r ^ pin_lvl_r) & in_mask) : '0; // R21 R5

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_s1_r  <= '0;
      pin_s2_r  <= '0;
      pin_s3_r  <= '0;
      pin_lvl_r <= '0;
      prime_r   <= 2'h0;
    end else if (ce) begin
      pin_s1_r  <= port_pin_i;
      pin_s2_r  <= pin_s1_r;
      pin_s3_r  <= pin_s2_r;
      pin_lvl_r <= primed ? ((pin_lvl_r & ~pin_agree) | (pin_s3_r & pin_agree)) : pin_s2_r; // R21
      if (!primed) prime_r <= prime_r + 2'h1;
    end
  end

  // set wins over the clear by a read
  assign change_flags_nxt = (rd_flags ? 8'h00 : change_flags_r) | 8'(pin_chg); // R19 R5

  always_ff @(posedge clk_sys) begin
    if (rst) change_flags_r <= smbus_io_pkg::RST_ZERO;
    else if (ce) change_flags_r <= change_flags_nxt;
  end

  // ***********************************************************************
  // alert
  // ***********************************************************************
  logic alert_r;
  logic alert_set;

  assign alert_set = global_irq_enable && |(pin_chg & change_irq_enable_bits_r[PINS-1:0]); // R6 R7 R12

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      alert_r   <= 1'b0;
      alert_n_o <= 1'b0;
    end else if (ce) begin
      alert_r   <= ((ara_ev || rd_flags) ? 1'b0 : alert_r) | alert_set; // R8
      alert_n_o <= 1'b0; // R9
    end
  end

  assign alert_n_oe   = alert_r; // R9
  assign xf.alert_lvl = alert_r;

  // ***********************************************************************
  // register reads
  // ***********************************************************************
  logic       ack_tgl_r;
  logic [7:0] rd_data_r;
  logic [7:0] levels_view;

  assign levels_view = 8'((port_levels_r[PINS-1:0] & out_mask) | (pin_lvl_r & ~out_mask));

  function automatic logic [7:0] read_mux(input logic [7:0] idx);
    unique case (idx)
      smbus_io_pkg::REG_DEVICE_CONFIG: return device_config_r;
      smbus_io_pkg::REG_PIN_DIRECTION: return pin_direction_r;
      smbus_io_pkg::REG_DRIVE_SELECT:  return drive_select_r;
      smbus_io_pkg::REG_CHANGE_FLAGS:  return change_flags_r;
      smbus_io_pkg::REG_IRQ_ENABLE:    return change_irq_enable_bits_r;
      smbus_io_pkg::REG_PORT_LEVELS:   return levels_view;
      smbus_io_pkg::REG_COOLING_RATE:  return cooling_rate_select_r;
      default:                         return 8'h00;
    endcase
  endfunction

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack_tgl_r <= 1'b0;
      rd_data_r <= 8'h00;
    end else if (ce && rd_ev) begin
      rd_data_r <= read_mux(xf.ev_idx); // R15 R19
      ack_tgl_r <= ~ack_tgl_r;
    end
  end

  assign xf.ack_tgl = ack_tgl_r;
  assign xf.rd_data = rd_data_r;

  // ***********************************************************************
  // pin drivers
  // ***********************************************************************
  logic [2:0] rate;
  logic [7:0] fan_vec;

  assign rate    = cooling_rate_select_r[smbus_io_pkg::RATE_MSB:0];
  assign fan_vec = {~rate, |rate, 4'h0}; // R20 R12

  genvar n;
  generate
    for (n = 0; n < PINS; n++) begin : g_pin
      logic fan_pin;
      logic val;
      assign fan_pin     = fan_on && n >= smbus_io_pkg::FAN_LO_PIN; // R11
      assign fan_mask[n] = fan_pin;
      assign out_mask[n] = !fan_pin && pin_direction_r[n]; // R17
      assign in_mask[n]  = !fan_pin && !pin_direction_r[n]; // R4 R12
      assign val         = fan_pin ? fan_vec[n] : port_levels_r[n]; // R11

      always_ff @(posedge clk_sys) begin
        if (rst) begin
          port_pin_o[n]  <= 1'b0;
          port_pin_oe[n] <= 1'b0;
        end else if (ce) begin
          if (fan_pin) begin
            port_pin_o[n]  <= 1'b0;
            port_pin_oe[n] <= !val; // R11
          end else if (out_mask[n] && drive_select_r[n]) begin
            port_pin_o[n]  <= val; // R18 R4
            port_pin_oe[n] <= 1'b1;
          end else begin
            port_pin_o[n]  <= 1'b0;
            port_pin_oe[n] <= out_mask[n] && !val; // R18 R4
          end
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

//--- hw/smbus_io_pkg.sv
package smbus_io_pkg;
  // ***********************************************************************
  // register indices and reset values
  // ***********************************************************************
  localparam logic [7:0] REG_DEVICE_CONFIG = 8'h00;
  localparam logic [7:0] REG_PIN_DIRECTION = 8'h01;
  localparam logic [7:0] REG_DRIVE_SELECT  = 8'h02;
  localparam logic [7:0] REG_CHANGE_FLAGS  = 8'h03;
  localparam logic [7:0] REG_IRQ_ENABLE    = 8'h04;
  localparam logic [7:0] REG_PORT_LEVELS   = 8'h05;
  localparam logic [7:0] REG_COOLING_RATE  = 8'h06;
  localparam logic [7:0] RST_ZERO          = 8'h00;
  localparam logic [7:0] RST_PORT_LEVELS   = 8'hFF;

  // ***********************************************************************
  // field positions
  // ***********************************************************************
  localparam int CFG_IE_BIT   = 0;
  localparam int CFG_FAN_BIT  = 1;
  localparam int FAN_LO_PIN   = 4;
  localparam int RATE_MSB     = 2;

  // ***********************************************************************
  // link addresses and timing
  // ***********************************************************************
  localparam logic [3:0] ADDR_UPPER   = 4'h4;
  localparam logic [6:0] ALERT_RESP   = 7'h0C;
  localparam logic [1:0] SETTLE_COUNT = 2'h3;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_BIT  = 4'h7;

  typedef enum logic [1:0] {EV_WRITE, EV_READ, EV_ARA} ev_kind_t;
endpackage

//--- hw/smbus_link_slave.sv
`timescale 1ns/100ps
`default_nettype none
module smbus_link_slave (
  input  wire logic       link_clk,
  input  wire logic       rst,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic [2:0] strap,
  output logic            sda_o,
  output logic            sda_oe,
  reg_xfer_if.link        xf
);
  typedef enum logic [3:0] {S_IDLE, S_ADDR, S_ADDR_ACK, S_CMD, S_CMD_ACK, S_WDATA,
                            S_WDATA_ACK, S_RDATA, S_RDATA_ACK, S_SKIP} link_state_t;

  // ***********************************************************************
  // synchronisers
  // ***********************************************************************
  logic [1:0] rst_s_r;
  logic       rst_l;
  logic [2:0] scl_s_r;
  logic [2:0] sda_s_r;
  logic [2:0] strap_s1_r;
  logic [2:0] strap_s2_r;
  logic [2:0] strap_s3_r;
  logic [1:0] alert_s_r;
  logic [2:0] ack_s_r;
  logic       scl_l_r;
  logic       sda_l_r;

  assign rst_l = rst_s_r[1];

  always_ff @(posedge link_clk) begin
    rst_s_r    <= {rst_s_r[0], rst};
    scl_s_r    <= {scl_s_r[1:0], scl_i};
    sda_s_r    <= {sda_s_r[1:0], sda_i};
    strap_s1_r <= strap;
    strap_s2_r <= strap_s1_r;
    strap_s3_r <= strap_s2_r;
    alert_s_r  <= {alert_s_r[0], xf.alert_lvl};
    ack_s_r    <= {ack_s_r[1:0], xf.ack_tgl};
  end

  logic scl_ok;
  logic sda_ok;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic ack_edge;

  assign scl_ok     = scl_s_r[1] == scl_s_r[2];
  assign sda_ok     = sda_s_r[1] == sda_s_r[2];
  assign scl_rise   = scl_ok && scl_s_r[2] && !scl_l_r;
  assign scl_fall   = scl_ok && !scl_s_r[2] && scl_l_r;
  assign start_seen = sda_ok && !sda_s_r[2] && sda_l_r && scl_l_r;
  assign stop_seen  = sda_ok && sda_s_r[2] && !sda_l_r && scl_l_r;
  assign ack_edge   = ack_s_r[2] ^ ack_s_r[1];

  always_ff @(posedge link_clk) begin
    if (rst_l) begin
      scl_l_r <= 1'b1;
      sda_l_r <= 1'b1;
    end else begin
      if (scl_ok) scl_l_r <= scl_s_r[2];
      if (sda_ok) sda_l_r <= sda_s_r[2];
    end
  end

  // ***********************************************************************
  // slave address, caught once after reset
  // ***********************************************************************
  logic [1:0] settle_r;
  logic [6:0] own_addr_r;
  logic       addr_ok_r;

  always_ff @(posedge link_clk) begin
    if (rst_l) begin
      settle_r   <= 2'h0;
      own_addr_r <= 7'h00;
      addr_ok_r  <= 1'b0;
    end else if (!addr_ok_r) begin
      if (settle_r != smbus_io_pkg::SETTLE_COUNT) begin
        settle_r <= settle_r + 2'h1;
      end else if (strap_s2_r == strap_s3_r) begin
        own_addr_r <= {smbus_io_pkg::ADDR_UPPER, strap_s3_r}; // R1 R2
        addr_ok_r  <= 1'b1;
      end
    end
  end

  // ***********************************************************************
  // byte engine
  // ***********************************************************************
  link_state_t            state_r;
  logic [3:0]             cnt_r;
  logic [7:0]             rx_r;
  logic [7:0]             tx_r;
  logic [7:0]             idx_r;
  logic                   rw_r;
  logic                   ara_r;
  logic                   sda_oe_r;
  logic                   ev_tgl_r;
  smbus_io_pkg::ev_kind_t ev_kind_r;
  logic [7:0]             ev_idx_r;
  logic [7:0]             ev_data_r;
  logic                   hit_own;
  logic                   hit_ara;

  assign hit_own = addr_ok_r && rx_r[7:1] == own_addr_r;
  assign hit_ara = rx_r[7:1] == smbus_io_pkg::ALERT_RESP && rx_r[0] && alert_s_r[1]; // R3

  always_ff @(posedge link_clk) begin
    if (rst_l) begin
      state_r   <= S_IDLE;
      cnt_r     <= 4'h0;
      rx_r      <= 8'h00;
      tx_r      <= 8'h00;
      idx_r     <= 8'h00;
      rw_r      <= 1'b0;
      ara_r     <= 1'b0;
      sda_oe_r  <= 1'b0;
      ev_tgl_r  <= 1'b0;
      ev_kind_r <= smbus_io_pkg::EV_WRITE;
      ev_idx_r  <= 8'h00;
      ev_data_r <= 8'h00;
    end else if (start_seen) begin
      state_r  <= S_ADDR;
      cnt_r    <= 4'h0;
      sda_oe_r <= 1'b0;
    end else if (stop_seen) begin
      state_r  <= S_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      if (ack_edge) tx_r <= xf.rd_data;
      unique case (state_r)
        S_ADDR, S_CMD, S_WDATA: begin
          if (scl_rise) begin
            rx_r  <= {rx_r[6:0], sda_l_r};
            cnt_r <= cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == smbus_io_pkg::BITS_PER_BYTE) begin
            cnt_r <= 4'h0;
            if (state_r == S_CMD) begin
              idx_r    <= rx_r; // R15
              sda_oe_r <= 1'b1;
              state_r  <= S_CMD_ACK;
            end else if (state_r == S_WDATA) begin
              ev_tgl_r  <= ~ev_tgl_r; // R14
              ev_kind_r <= smbus_io_pkg::EV_WRITE;
              ev_idx_r  <= idx_r;
              ev_data_r <= rx_r;
              sda_oe_r  <= 1'b1;
              state_r   <= S_WDATA_ACK;
            end else if (hit_own || hit_ara) begin
              sda_oe_r <= 1'b1;
              rw_r     <= rx_r[0];
              ara_r    <= !hit_own;
              state_r  <= S_ADDR_ACK;
              if (!hit_own) tx_r <= {own_addr_r, 1'b0}; // R3
              if (hit_own && rx_r[0]) begin
                ev_tgl_r  <= ~ev_tgl_r; // R13
                ev_kind_r <= smbus_io_pkg::EV_READ;
                ev_idx_r  <= idx_r;
              end
            end else begin
              state_r <= S_SKIP;
            end
          end
        end
        S_ADDR_ACK: begin
          if (scl_fall) begin
            state_r  <= rw_r ? S_RDATA : S_CMD;
            sda_oe_r <= rw_r && !tx_r[7];
          end
        end
        S_CMD_ACK: begin
          if (scl_fall) begin
            state_r  <= S_WDATA;
            sda_oe_r <= 1'b0;
          end
        end
        S_WDATA_ACK: begin
          if (scl_fall) begin
            state_r  <= S_SKIP;
            sda_oe_r <= 1'b0;
          end
        end
        S_RDATA: begin
          if (scl_fall) begin
            if (cnt_r == smbus_io_pkg::LAST_TX_BIT) begin
              sda_oe_r <= 1'b0;
              state_r  <= S_RDATA_ACK;
            end else begin
              cnt_r    <= cnt_r + 4'h1;
              tx_r     <= {tx_r[6:0], 1'b0};
              sda_oe_r <= !tx_r[6]; // R10
            end
          end
        end
        S_RDATA_ACK: begin
          if (scl_fall) begin
            state_r <= S_SKIP;
            if (ara_r) begin
              ev_tgl_r  <= ~ev_tgl_r; // R8
              ev_kind_r <= smbus_io_pkg::EV_ARA;
            end
          end
        end
        S_IDLE, S_SKIP: begin
        end
      endcase
    end
  end

  assign sda_o      = 1'b0; // R10
  assign sda_oe     = sda_oe_r;
  assign xf.ev_tgl  = ev_tgl_r;
  assign xf.ev_kind = ev_kind_r;
  assign xf.ev_idx  = ev_idx_r;
  assign xf.ev_data = ev_data_r;
endmodule
`default_nettype wire
